// [rtl/fmc_pkg.sv]
/*
  Shared constants and types of the flame monitor configuration checker:
  timing, register offsets, field positions, reset values and the
  checker state encoding.
  Assumes a single 100 MHz clock.
*/
package fmc_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int MISMATCH_TIME_MS = 8000;
  localparam int MISMATCH_TICKS = MISMATCH_TIME_MS * (1_000_000 / TICK_TIME_NS);
  localparam int DIV_W = 17;
  localparam int MS_W = 13;

  // synchroniser width: two banks, address switch, range line, thresholds
  localparam int SYNC_W = 40;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_STATE = 4'h2;
  localparam logic [3:0] REG_CONFIG = 4'h3;

  // event bits, shared by status and mask
  localparam int EVT_W = 5;
  localparam int EV_MISMATCH = 0;
  localparam int EV_SHUTDOWN = 1;
  localparam int EV_FLAME_ON = 2;
  localparam int EV_FLAME_OFF = 3;
  localparam int EV_LINE_BREAK = 4;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;

  // gain switch layout: position n sits in bit n-1
  localparam int SAFETY_LSB = 0;
  localparam int RANGE_A_LSB = 2;
  localparam int RANGE_B_LSB = 5;
  localparam logic [3:0] CURVE_TOP = 4'h8;

  // bus address: switch value plus one gives 1..64
  localparam logic [6:0] ADDR_BASE = 7'h01;
  localparam logic [6:0] ADDR_MAX = 7'h40;

  // config register field positions
  localparam int CFG_SAFETY_LSB = 4;
  localparam int CFG_ADDR_LSB = 6;

  typedef enum logic [2:0] {
    ST_AGREE = 3'b001,
    ST_MISMATCH = 3'b010,
    ST_SHUTDOWN = 3'b100
  } fmc_chk_t;

endpackage

// [rtl/fmc_sync3.sv]
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; an output bit follows only once stages two
  and three agree, so a single metastable sample never reaches the logic.
*/
`timescale 1ns/100ps
module fmc_sync3 #(
  parameter int WIDTH = fmc_pkg::SYNC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import fmc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } fmc_sync_t;

  fmc_sync_t state_ff;
  fmc_sync_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.s1 = d;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (state_ff.s2[i] == state_ff.s3[i])
      begin
        nxt_state.q[i] = state_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign q = state_ff.q;

endmodule // fmc_sync3

// [rtl/fmc_config_check.sv]
/*
  Configuration switch decoder and cross-checker of a dual-channel flame
  monitor: gain curve decode, bank mismatch timing with error shutdown,
  range selection with fail-safe, bus address, flame relay and indicator,
  and a small register port with a masked interrupt.
  Assumes switch and line inputs are asynchronous pins, the measured
  intensity and flicker codes come from logic on MCLK.
*/
`timescale 1ns/100ps
module fmc_config_check #(
  parameter int unsigned TICK_CYC = fmc_pkg::TICK_CYCLES,
  parameter int unsigned MISMATCH_TICKS = fmc_pkg::MISMATCH_TICKS
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] GAIN_BANK_ONE,
  input wire logic [7:0] GAIN_BANK_TWO,
  input wire logic [5:0] BUS_ADDRESS_SWITCH,
  input wire logic RANGE_B_REQ,
  input wire logic RANGE_LINE_OK,
  input wire logic [3:0] INT_THR_A,
  input wire logic [3:0] FLK_THR_A,
  input wire logic [3:0] INT_THR_B,
  input wire logic [3:0] FLK_THR_B,
  input wire logic [3:0] MEAS_INTENSITY,
  input wire logic [3:0] MEAS_FLICKER,
  input wire logic [fmc_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [fmc_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output logic [fmc_pkg::DATA_W-1:0] REG_RDATA,
  output logic [3:0] GAIN_CURVE_A,
  output logic [3:0] GAIN_CURVE_B,
  output logic [3:0] GAIN_CURVE,
  output logic [1:0] SAFETY_SEL,
  output logic RANGE_B_ACTIVE,
  output logic [3:0] INT_THR_ACT,
  output logic [3:0] FLK_THR_ACT,
  output logic SWITCH_ERR_LED,
  output logic ERROR_SHUTDOWN,
  output logic [6:0] MB_ADDR,
  output logic FLAME_RELAY,
  output logic FLAME_LED_GREEN,
  output logic IRQ
);
  import fmc_pkg::*;

  typedef struct packed {
    fmc_chk_t chk;
    logic [DIV_W-1:0] div;
    logic [MS_W-1:0] ms;
    logic [3:0] curve_a;
    logic [3:0] curve_b;
    logic [3:0] curve;
    logic [1:0] safety;
    logic range_b;
    logic [3:0] int_thr;
    logic [3:0] flk_thr;
    logic relay;
    logic err_led;
    logic [6:0] addr;
    logic line_ok_d;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } fmc_state_t;

  fmc_state_t state_ff;
  fmc_state_t nxt_state;
  logic [SYNC_W-1:0] sync_q;
  logic [7:0] bank_one;
  logic [7:0] bank_two;
  logic [5:0] addr_sw;
  logic range_req;
  logic line_ok;
  logic [3:0] int_thr_a;
  logic [3:0] flk_thr_a;
  logic [3:0] int_thr_b;
  logic [3:0] flk_thr_b;
  logic bank_eq;
  logic tick;
  logic flame_now;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] w1c;

  fmc_sync3 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d({GAIN_BANK_ONE, GAIN_BANK_TWO, BUS_ADDRESS_SWITCH, RANGE_B_REQ,
        RANGE_LINE_OK, INT_THR_A, FLK_THR_A, INT_THR_B, FLK_THR_B}),
    .q(sync_q)
  );

  assign {bank_one, bank_two, addr_sw, range_req, line_ok, int_thr_a,
          flk_thr_a, int_thr_b, flk_thr_b} = sync_q;

  // whole bytes compared: positions 1 and 2 are checked and decoded to SAFETY_SEL
  assign bank_eq = bank_one == bank_two;
  assign tick = state_ff.div == DIV_W'(TICK_CYC - 1);
  // flicker threshold zero switches the flicker test off
  assign flame_now = (MEAS_INTENSITY > state_ff.int_thr) &&
                     ((state_ff.flk_thr == 4'h0) ||
                      (MEAS_FLICKER > state_ff.flk_thr));
  assign w1c = (REG_WE && REG_ADDR == REG_STATUS) ?
               REG_WDATA[EVT_W-1:0] : '0;

  always_comb
  begin
    nxt_state = state_ff;
    evt = '0;
    unique case (state_ff.chk)
      ST_AGREE:
      begin
        if (!bank_eq)
        begin
          nxt_state.chk = ST_MISMATCH;
          nxt_state.div = '0;
          nxt_state.ms = '0;
          evt[EV_MISMATCH] = 1'b1;
        end
        else
        begin
          // curves only follow a settled, agreeing pair of banks
          nxt_state.curve_a = CURVE_TOP -
            {1'b0, bank_one[RANGE_A_LSB +: 3]};
          nxt_state.curve_b = CURVE_TOP -
            {1'b0, bank_one[RANGE_B_LSB +: 3]};
          nxt_state.safety = bank_one[SAFETY_LSB +: 2];
        end
      end
      ST_MISMATCH:
      begin
        if (bank_eq)
        begin
          nxt_state.chk = ST_AGREE;
          nxt_state.div = '0;
          nxt_state.ms = '0;
        end
        else if (tick)
        begin
          nxt_state.div = '0;
          if (state_ff.ms == MS_W'(MISMATCH_TICKS - 1))
          begin
            nxt_state.chk = ST_SHUTDOWN;
            evt[EV_SHUTDOWN] = 1'b1;
          end
          else
          begin
            nxt_state.ms = state_ff.ms + MS_W'(1);
          end
        end
        else
        begin
          nxt_state.div = state_ff.div + DIV_W'(1);
        end
      end
      ST_SHUTDOWN:
      begin
        // latched until reset: a safety shutdown is never self-clearing
        nxt_state.chk = ST_SHUTDOWN;
      end
    endcase
    nxt_state.err_led = nxt_state.chk != ST_AGREE;

    // range choice; a broken line falls back to set A
    nxt_state.range_b = line_ok && range_req;
    nxt_state.curve = nxt_state.range_b ?
                      nxt_state.curve_b : nxt_state.curve_a;
    nxt_state.int_thr = nxt_state.range_b ? int_thr_b : int_thr_a;
    nxt_state.flk_thr = nxt_state.range_b ? flk_thr_b : flk_thr_a;

    nxt_state.addr = {1'b0, addr_sw} + ADDR_BASE;
    nxt_state.relay = flame_now && nxt_state.chk != ST_SHUTDOWN;
    evt[EV_FLAME_ON] = nxt_state.relay && !state_ff.relay;
    evt[EV_FLAME_OFF] = !nxt_state.relay && state_ff.relay;
    nxt_state.line_ok_d = line_ok;
    evt[EV_LINE_BREAK] = state_ff.line_ok_d && !line_ok;

    // set wins over a same-cycle write-one-to-clear
    nxt_state.status = (state_ff.status & ~w1c) | evt;
    if (REG_WE && REG_ADDR == REG_MASK)
    begin
      nxt_state.mask = REG_WDATA[EVT_W-1:0];
    end
    nxt_state.irq = |(nxt_state.status & nxt_state.mask);

    nxt_state.rdata = '0;
    if (REG_RE)
    begin
      unique case (REG_ADDR)
        REG_STATUS: nxt_state.rdata = DATA_W'(state_ff.status);
        REG_MASK: nxt_state.rdata = DATA_W'(state_ff.mask);
        REG_STATE: nxt_state.rdata = DATA_W'({state_ff.chk,
          state_ff.range_b, state_ff.line_ok_d, state_ff.err_led,
          state_ff.chk == ST_SHUTDOWN, state_ff.relay});
        REG_CONFIG:
        begin
          nxt_state.rdata[3:0] = state_ff.curve;
          nxt_state.rdata[CFG_SAFETY_LSB +: 2] = state_ff.safety;
          nxt_state.rdata[CFG_ADDR_LSB +: 7] = state_ff.addr;
        end
        default: nxt_state.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_ff <= '{chk: ST_AGREE, curve_a: CURVE_TOP, curve_b: CURVE_TOP,
                    curve: CURVE_TOP, addr: ADDR_BASE, status: STATUS_RST,
                    mask: MASK_RST, default: '0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign REG_RDATA = state_ff.rdata;
  assign GAIN_CURVE_A = state_ff.curve_a;
  assign GAIN_CURVE_B = state_ff.curve_b;
  assign GAIN_CURVE = state_ff.curve;
  assign SAFETY_SEL = state_ff.safety;
  assign RANGE_B_ACTIVE = state_ff.range_b;
  assign INT_THR_ACT = state_ff.int_thr;
  assign FLK_THR_ACT = state_ff.flk_thr;
  assign SWITCH_ERR_LED = state_ff.err_led;
  // one-hot state: the shutdown code's own bit is a flop, no decode needed
  assign ERROR_SHUTDOWN = state_ff.chk[2];
  assign MB_ADDR = state_ff.addr;
  assign FLAME_RELAY = state_ff.relay;
  assign FLAME_LED_GREEN = state_ff.relay;
  assign IRQ = state_ff.irq;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  a_curve_a_decode: assert property (
    (state_ff.chk == ST_AGREE && bank_eq) |=>
      GAIN_CURVE_A == CURVE_TOP - {1'b0, $past(bank_one[4:2])})
    else $error("range A curve decode wrong");
  a_curve_b_decode: assert property (
    (state_ff.chk == ST_AGREE && bank_eq) |=>
      GAIN_CURVE_B == CURVE_TOP - {1'b0, $past(bank_one[7:5])})
    else $error("range B curve decode wrong");
  a_safety_kept_apart: assert property (
    (state_ff.chk == ST_AGREE && bank_eq) |=>
      SAFETY_SEL == $past(bank_one[1:0]))
    else $error("positions 1 and 2 misrouted");
  a_err_led_on: assert property (
    !bank_eq |=> SWITCH_ERR_LED && (!$rose(ERROR_SHUTDOWN) ||
      $past(tick)))
    else $error("switch error LED not lit on mismatch");
  a_shutdown_expiry: assert property (
    (state_ff.chk == ST_MISMATCH && !bank_eq && tick &&
     state_ff.ms == MS_W'(MISMATCH_TICKS - 1)) |=> ERROR_SHUTDOWN)
    else $error("no shutdown at mismatch expiry");
  a_no_early_stop: assert property (
    $rose(ERROR_SHUTDOWN) |->
      $past(state_ff.ms) == MS_W'(MISMATCH_TICKS - 1) && $past(tick))
    else $error("shutdown before full mismatch time");
  a_range_b_used: assert property (
    (range_req && line_ok) |=>
      RANGE_B_ACTIVE && GAIN_CURVE == GAIN_CURVE_B &&
      INT_THR_ACT == $past(int_thr_b) && FLK_THR_ACT == $past(flk_thr_b))
    else $error("range B set not applied");
  a_failsafe_range_a: assert property (
    !line_ok |=> !RANGE_B_ACTIVE && GAIN_CURVE == GAIN_CURVE_A &&
      INT_THR_ACT == $past(int_thr_a))
    else $error("broken line did not force range A");
  a_addr_follow: assert property (
    1'b1 |=> MB_ADDR == {1'b0, $past(addr_sw)} + ADDR_BASE &&
      MB_ADDR >= ADDR_BASE && MB_ADDR <= ADDR_MAX)
    else $error("bus address out of step or range");
  a_addr_default: assert property (
    addr_sw == 6'h00 |=> MB_ADDR == ADDR_BASE)
    else $error("default switch does not give address 1");
  a_relay_led_pair: assert property (
    FLAME_RELAY == FLAME_LED_GREEN && !(FLAME_RELAY && ERROR_SHUTDOWN))
    else $error("relay and green LED disagree");
  a_flicker_disabled: assert property (
    (state_ff.flk_thr == 4'h0 && MEAS_INTENSITY > state_ff.int_thr &&
     state_ff.chk == ST_AGREE && bank_eq) |=> FLAME_RELAY)
    else $error("zero flicker threshold still gates flame");
  a_flicker_gates: assert property (
    (state_ff.flk_thr != 4'h0 && MEAS_FLICKER <= state_ff.flk_thr)
      |=> !FLAME_RELAY)
    else $error("flicker below threshold gave flame on");
  a_timer_clears: assert property (
    (state_ff.chk == ST_MISMATCH && bank_eq) |=>
      !SWITCH_ERR_LED && state_ff.ms == '0 && state_ff.div == '0)
    else $error("agreement did not clear mismatch timer");

  c_mismatch_recover: cover property (
    state_ff.chk == ST_MISMATCH ##1 state_ff.chk == ST_AGREE);
  c_shutdown: cover property ($rose(ERROR_SHUTDOWN));
  c_range_b_flame: cover property (RANGE_B_ACTIVE && FLAME_RELAY);
  c_line_break_irq: cover property (evt[EV_LINE_BREAK] ##1 IRQ);

endmodule // fmc_config_check

// [test/fmc_burner_ctl.sv]
/*
  Behavioural burner control driving the range select line.
  Assumes the bench commands range choice and line breaks on MCLK.
*/
`timescale 1ns/100ps
module fmc_burner_ctl (
  input wire logic clk,
  input wire logic want_b,
  input wire logic broken,
  output logic range_b_req,
  output logic range_line_ok
);
  logic junk_ff = 1'b0;

  // a broken line floats: toggle it so no level is read by luck
  always @(posedge clk)
  begin
    junk_ff <= ~junk_ff;
  end

  assign range_b_req = broken ? junk_ff : want_b;
  assign range_line_ok = ~broken;
endmodule // fmc_burner_ctl

// [test/tb_top.sv]
/*
  Self-checking bench of the configuration checker: decode, range,
  flame relay, bank mismatch timing, register port and interrupt.
  Assumes the design runs with a shortened tick and mismatch count.
*/
`timescale 1ns/100ps
module tb_top;
  import fmc_pkg::*;
  localparam int TC = 4;
  localparam int MT = 5;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] bank1 = 8'h00;
  logic [7:0] bank2 = 8'h00;
  logic [5:0] asw = 6'h00;
  logic want_b = 1'b0;
  logic broken = 1'b0;
  logic rb, rok, we = 1'b0, re = 1'b0;
  logic [3:0] ita = 4'h0, fta = 4'h0, itb = 4'h0, ftb = 4'h0;
  logic [3:0] mi = 4'h0, mf = 4'h0;
  logic [3:0] raddr = 4'h0;
  logic [15:0] rwdata = 16'h0000;
  logic [15:0] rdata, rv;
  logic [3:0] ca, cb, cur, ith, fth;
  logic [1:0] ssel;
  logic [6:0] mba;
  logic rba, err, sd, rel, grn, irq;
  logic [7:0] g;
  logic [5:0] sw;
  int bad_count = 0;
  int tests_run = 0;
  int seed = 32'h4758960e;
  int i;

  always #5 mclk = ~mclk;

  fmc_burner_ctl fmc_burner_ctl_i (.clk(mclk), .want_b(want_b),
    .broken(broken), .range_b_req(rb), .range_line_ok(rok));

  fmc_config_check #(.TICK_CYC(TC), .MISMATCH_TICKS(MT)) fmc_config_check_i (
    .MCLK(mclk), .RST_N(rst_n), .GAIN_BANK_ONE(bank1),
    .GAIN_BANK_TWO(bank2), .BUS_ADDRESS_SWITCH(asw), .RANGE_B_REQ(rb),
    .RANGE_LINE_OK(rok), .INT_THR_A(ita), .FLK_THR_A(fta),
    .INT_THR_B(itb), .FLK_THR_B(ftb), .MEAS_INTENSITY(mi),
    .MEAS_FLICKER(mf), .REG_ADDR(raddr), .REG_WDATA(rwdata), .REG_WE(we),
    .REG_RE(re), .REG_RDATA(rdata), .GAIN_CURVE_A(ca), .GAIN_CURVE_B(cb),
    .GAIN_CURVE(cur), .SAFETY_SEL(ssel), .RANGE_B_ACTIVE(rba),
    .INT_THR_ACT(ith), .FLK_THR_ACT(fth), .SWITCH_ERR_LED(err),
    .ERROR_SHUTDOWN(sd), .MB_ADDR(mba), .FLAME_RELAY(rel),
    .FLAME_LED_GREEN(grn), .IRQ(irq));

  function automatic logic [3:0] curve(input logic [2:0] f);
    return CURVE_TOP - {1'b0, f};
  endfunction

  function automatic logic flame(input logic [3:0] m, k, t, ft);
    return (m > t) && ((ft == 4'h0) || (k > ft));
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // lands just after the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    raddr <= a;
    rwdata <= d;
    we <= 1'b1;
    @(posedge mclk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    raddr <= a;
    re <= 1'b1;
    @(posedge mclk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic results;
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    bad_count++;
    $display("ERROR %0t: watchdog expired", $time);
    results;
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(8);
    chk(mba, 16'h0001);
    $display("reset test done");
    for (i = 0; i < 8; i++)
    begin
      g = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      if (i == 7) g = g ^ 8'h03; // only the fixed positions move
      sw = (i == 1) ? 6'h3f : 6'($random(seed));
      @(posedge mclk);
      bank1 <= g;
      bank2 <= g;
      asw <= sw;
      cyc(8);
      chk(ca, curve(g[4:2]));
      chk(cb, curve(g[7:5]));
      chk(ssel, g[1:0]);
      chk(mba, {1'b0, sw} + 7'h01);
    end
    $display("decode test done");
    @(posedge mclk);
    ita <= 4'($random(seed));
    fta <= 4'($random(seed));
    itb <= 4'($random(seed));
    ftb <= 4'($random(seed));
    want_b <= 1'b1;
    cyc(8);
    chk(rba, 16'h0001);
    chk(cur, curve(g[7:5]));
    chk({fth, ith}, {ftb, itb});
    wr(REG_MASK, 16'h0010);
    @(posedge mclk);
    broken <= 1'b1;
    cyc(8);
    chk(rba, 16'h0000);
    chk(cur, curve(g[4:2]));
    chk({fth, ith}, {fta, ita});
    chk(irq, 16'h0001);
    @(posedge mclk);
    broken <= 1'b0;
    want_b <= 1'b0;
    $display("range test done");
    for (i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      mi <= 4'($random(seed));
      mf <= 4'($random(seed));
      ita <= 4'($random(seed));
      fta <= (i < 4) ? 4'h0 : 4'($random(seed));
      cyc(8);
      chk(rel, flame(mi, mf, ita, fta));
      chk(grn, flame(mi, mf, ita, fta));
    end
    $display("flame test done");
    wr(REG_STATUS, 16'h001f);
    @(posedge mclk);
    bank2 <= g ^ 8'h04;
    cyc(8);
    chk(err, 16'h0001);
    chk(irq, 16'h0000);
    chk(ca, curve(g[4:2]));
    rd(REG_STATE, rv);
    chk(rv[7:5], 3'b010);
    @(posedge mclk);
    bank2 <= g; // banks agree again well inside the limit
    cyc(8);
    chk(err, 16'h0000);
    cyc(30);
    chk(sd, 16'h0000);
    rd(REG_STATUS, rv);
    chk(rv[EV_MISMATCH], 16'h0001);
    wr(REG_MASK, 16'h0001);
    cyc(2);
    chk(irq, 16'h0001);
    rd(REG_MASK, rv);
    chk(rv, 16'h0001);
    wr(REG_STATUS, 16'h0001);
    cyc(2);
    chk(irq, 16'h0000);
    rd(4'h9, rv);
    chk(rv, 16'h0000);
    wr(REG_CONFIG, 16'hffff);
    rd(REG_CONFIG, rv);
    chk(rv[12:6], {1'b0, sw} + 7'h01);
    $display("register test done");
    @(posedge mclk);
    mi <= 4'hf;
    ita <= 4'h0;
    fta <= 4'h0;
    cyc(8);
    chk(rel, 16'h0001);
    wr(REG_MASK, 16'h0002);
    @(posedge mclk);
    bank2 <= g ^ 8'h80;
    cyc(14);
    chk(sd, 16'h0000);
    cyc(26);
    chk(sd, 16'h0001);
    chk(err, 16'h0001);
    chk(rel, 16'h0000);
    chk(irq, 16'h0001);
    rd(REG_STATE, rv);
    chk(rv[7:5], 3'b100);
    rd(REG_STATUS, rv);
    chk({rv[EV_FLAME_OFF], rv[EV_SHUTDOWN]}, 2'b11);
    $display("shutdown test done");
    results;
  end
endmodule // tb_top
